// *** logic/acg_pkg.sv ***
// acg_pkg: register map, field layout and reset values of the channel configuration bank
// What this block does
// RULE1: averaging code 0 none, else 2..128 samples
// RULE2: oscillator bit 0 fast, 1 low power
// RULE3: four-bit sampling divider, resets to 100b
// RULE4: function bit 0 analog, 1 digital pin
// RULE5: direction bit 0 input, 1 output
// RULE6: drive bit 0 open-drain, 1 push-pull
// RULE7: digital output follows output level bit
// RULE8: read-only register returns pin levels
// RULE9: auto mode runs ascending while run set
// RULE10: scan mode 00 manual, 01 auto, 10 fly
// RULE11: force bit makes every channel analog
// RULE12: manual mode converts manual field channel
// RULE13: auto scan includes only enabled channels
// RULE14: reserved bits read zero, writes ignored
// RULE15: reset clears all, mode register loads 0x4; the code clears the scan mode and loads 0x4 into the timing register
package acg_pkg;
    localparam int          ACG_AW              = 8;
    localparam int          ACG_DW              = 8;
    localparam int          ACG_NCH             = 8;

    // register offsets
    localparam logic [7:0]  ACG_OFF_OVERRIDE    = 8'h01;
    localparam logic [7:0]  ACG_OFF_AVG         = 8'h03;
    localparam logic [7:0]  ACG_OFF_TIMING      = 8'h04;
    localparam logic [7:0]  ACG_OFF_FUNC        = 8'h05;
    localparam logic [7:0]  ACG_OFF_DIR         = 8'h07;
    localparam logic [7:0]  ACG_OFF_DRIVE       = 8'h09;
    localparam logic [7:0]  ACG_OFF_OUTLVL      = 8'h0b;
    localparam logic [7:0]  ACG_OFF_INLVL       = 8'h0d;
    localparam logic [7:0]  ACG_OFF_SCAN        = 8'h10;
    localparam logic [7:0]  ACG_OFF_MANUAL      = 8'h11;
    localparam logic [7:0]  ACG_OFF_ENMASK      = 8'h12;

    // writable bit masks
    localparam logic [7:0]  ACG_MSK_OVERRIDE    = 8'h04;
    localparam logic [7:0]  ACG_MSK_AVG         = 8'h07;
    localparam logic [7:0]  ACG_MSK_TIMING      = 8'h1f;
    localparam logic [7:0]  ACG_MSK_SCAN        = 8'h13;
    localparam logic [7:0]  ACG_MSK_MANUAL      = 8'h0f;

    // field positions
    localparam int          ACG_BIT_FORCE       = 2;
    localparam int          ACG_BIT_OSC         = 4;
    localparam int          ACG_BIT_RUN         = 4;
    localparam int          ACG_LSB_DIV         = 0;
    localparam int          ACG_LSB_MODE        = 0;

    // reset values
    localparam logic [7:0]  ACG_RST_ZERO        = 8'h00;
    localparam logic [7:0]  ACG_RST_TIMING      = 8'h04;

    typedef enum logic [1:0] {
        ACG_SCAN_MANUAL   = 2'b00,
        ACG_SCAN_AUTO     = 2'b01,
        ACG_SCAN_FLY      = 2'b10,
        ACG_SCAN_RESERVED = 2'b11
    } acg_scan_mode_t;
endpackage

// *** logic/acg_cfg_if.sv ***
// acg_cfg_if: scan settings passed from the register bank to the channel sequencer
`timescale 1ns/100ps
interface acg_cfg_if;
    import acg_pkg::*;
    acg_scan_mode_t   scan_mode;
    logic             scan_run;
    logic [3:0]       manual_channel_field;
    logic [7:0]       scan_enable_mask;
    logic [7:0]       analog_mask;

    modport reg_side (output scan_mode, scan_run, manual_channel_field, scan_enable_mask, analog_mask);
    modport seq_side (input scan_mode, scan_run, manual_channel_field, scan_enable_mask, analog_mask);
endinterface

// *** logic/acg_pin_sync.sv ***
// acg_pin_sync: three-stage synchroniser per pin with agreement filter
`timescale 1ns/100ps
module acg_pin_sync #(
    parameter int N = 8
) (
    input  wire logic         clk_in,
    input  wire logic         resetn_in,
    input  wire logic [N-1:0] pin_in,
    output logic      [N-1:0] level_out
);
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_sync
            logic s1_q;
            logic s2_q;
            logic s3_q;
            logic lvl_q;
            always_ff @(posedge clk_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    s1_q  <= 1'b0;
                    s2_q  <= 1'b0;
                    s3_q  <= 1'b0;
                    lvl_q <= 1'b0;
                end else begin
                    s1_q <= pin_in[i];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q) begin
                        lvl_q <= s3_q;
                    end
                end
            end
            assign level_out[i] = lvl_q;
        end
    endgenerate
endmodule

// *** logic/acg_sequencer.sv ***
// acg_sequencer: picks the next channel to convert from the scan settings
`timescale 1ns/100ps
module acg_sequencer
    import acg_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       resetn_in,
    acg_cfg_if.seq_side     cfg,
    input  wire logic       conv_done_in,
    output logic [2:0]      channel_out,
    output logic            channel_valid_out
);
    logic [7:0] cand;
    logic [2:0] chan_q;
    logic [2:0] chan_d;
    logic       valid_q;
    logic       valid_d;
    logic       run_q;

    // next enabled channel strictly above cur, wrapping
    function automatic logic [2:0] next_chan(input logic [7:0] m, input logic [2:0] cur);
        logic [2:0] idx;
        logic [2:0] res;
        res = cur;
        for (int k = 8; k >= 1; k--) begin
            idx = cur + k[2:0];
            if (m[idx]) res = idx;
        end
        return res;
    endfunction

    assign cand = cfg.scan_enable_mask & cfg.analog_mask; // RULE13

    always_comb begin
        chan_d  = chan_q;
        valid_d = 1'b0;
        unique case (cfg.scan_mode)
            ACG_SCAN_MANUAL, ACG_SCAN_FLY: begin
                chan_d  = cfg.manual_channel_field[2:0]; // RULE12
                valid_d = !cfg.manual_channel_field[3] && cfg.analog_mask[cfg.manual_channel_field[2:0]]; // RULE12
            end
            ACG_SCAN_AUTO: begin
                valid_d = cfg.scan_run && (cand != 8'h00); // RULE9
                if (cfg.scan_run && !run_q) begin
                    chan_d = next_chan(cand, 3'h7); // RULE9
                end else if (cfg.scan_run && (conv_done_in || !cand[chan_q])) begin
                    chan_d = next_chan(cand, chan_q); // RULE9
                end
            end
            ACG_SCAN_RESERVED: begin
                valid_d = 1'b0; // RULE10
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            chan_q  <= 3'h0;
            valid_q <= 1'b0;
            run_q   <= 1'b0;
        end else begin
            chan_q  <= chan_d;
            valid_q <= valid_d;
            run_q   <= cfg.scan_run && (cfg.scan_mode == ACG_SCAN_AUTO);
        end
    end

    assign channel_out       = chan_q;
    assign channel_valid_out = valid_q;
endmodule

// *** logic/acg_regs.sv ***
// acg_regs: channel, digital pin and scan configuration register bank
`timescale 1ns/100ps
module acg_regs
    import acg_pkg::*;
(
    input  wire logic [ACG_AW-1:0]  addr_in,
    input  wire logic [ACG_DW-1:0]  wdata_in,
    input  wire logic               wr_in,
    input  wire logic               rd_in,
    output logic      [ACG_DW-1:0]  rdata_out,
    input  wire logic               clk_in,
    input  wire logic               resetn_in,
    input  wire logic [7:0]         pin_in,
    output logic      [7:0]         pin_out,
    output logic      [7:0]         pin_oe_out,
    input  wire logic               conv_done_in,
    output logic      [2:0]         averaging_ratio_out,
    output logic      [7:0]         average_samples_out,
    output logic                    oscillator_choice_out,
    output logic      [3:0]         sample_divider_out,
    output logic      [7:0]         analog_mask_out,
    output logic      [1:0]         scan_mode_out,
    output logic                    scan_run_out,
    output logic      [2:0]         channel_out,
    output logic                    channel_valid_out
);
    acg_cfg_if cfg ();

    logic [7:0]          override_q;
    logic [7:0]          avg_q;
    logic [7:0]          timing_q;
    logic [7:0]          func_q;
    logic [7:0]          dir_q;
    logic [7:0]          drive_q;
    logic [7:0]          outlvl_q;
    logic [7:0]          scan_q;
    logic [7:0]          manual_q;
    logic [7:0]          enmask_q;
    logic [7:0]          inlvl_q;
    logic [7:0]          pin_out_q;
    logic [7:0]          pin_oe_q;
    logic [ACG_DW-1:0]   rdata_q;
    logic [ACG_DW-1:0]   rdata_d;
    logic [7:0]          samples_q;
    logic [7:0]          pin_level;
    logic [7:0]          digital_mask;
    logic [7:0]          output_mask;
    logic                force_analog;

    // write decode, shared by every writable register
    function automatic logic hit(input logic [ACG_AW-1:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    acg_pin_sync #(
        .N          (ACG_NCH)
    ) u_sync (
        .clk_in     (clk_in),
        .resetn_in  (resetn_in),
        .pin_in     (pin_in),
        .level_out  (pin_level)
    );

    // channel role derivation
    assign force_analog = override_q[ACG_BIT_FORCE];                 // RULE11
    assign digital_mask = force_analog ? 8'h00 : func_q;             // RULE4
    assign output_mask  = digital_mask & dir_q;                      // RULE5

    // override register: force-all-analog bit only
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            override_q <= ACG_RST_ZERO; // RULE15
        end else if (wr_in && hit(addr_in, ACG_OFF_OVERRIDE)) begin
            override_q <= wdata_in & ACG_MSK_OVERRIDE; // RULE14
        end
    end

    // averaging ratio
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            avg_q <= ACG_RST_ZERO; // RULE15
        end else if (wr_in && hit(addr_in, ACG_OFF_AVG)) begin
            avg_q <= wdata_in & ACG_MSK_AVG; // RULE14
        end
    end

    // sample count: code 0 gives one conversion, else two to the code
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            samples_q <= 8'h01;
        end else begin
            samples_q <= 8'h01 << avg_q[2:0]; // RULE1
        end
    end

    // oscillator and divider
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            timing_q <= ACG_RST_TIMING; // RULE3 RULE15
        end else if (wr_in && hit(addr_in, ACG_OFF_TIMING)) begin
            timing_q <= wdata_in & ACG_MSK_TIMING; // RULE14
        end
    end

    // pin function mask
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            func_q <= ACG_RST_ZERO; // RULE15
        end else if (wr_in && hit(addr_in, ACG_OFF_FUNC)) begin
            func_q <= wdata_in; // RULE4
        end
    end

    // direction mask
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            dir_q <= ACG_RST_ZERO; // RULE15
        end else if (wr_in && hit(addr_in, ACG_OFF_DIR)) begin
            dir_q <= wdata_in; // RULE5
        end
    end

    // drive type mask
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            drive_q <= ACG_RST_ZERO; // RULE15
        end else if (wr_in && hit(addr_in, ACG_OFF_DRIVE)) begin
            drive_q <= wdata_in; // RULE6
        end
    end

    // output level
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            outlvl_q <= ACG_RST_ZERO; // RULE15
        end else if (wr_in && hit(addr_in, ACG_OFF_OUTLVL)) begin
            outlvl_q <= wdata_in; // RULE7
        end
    end

    // scan control
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            scan_q <= ACG_RST_ZERO; // RULE15
        end else if (wr_in && hit(addr_in, ACG_OFF_SCAN)) begin
            scan_q <= wdata_in & ACG_MSK_SCAN; // RULE14
        end
    end

    // manual channel
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            manual_q <= ACG_RST_ZERO; // RULE15
        end else if (wr_in && hit(addr_in, ACG_OFF_MANUAL)) begin
            manual_q <= wdata_in & ACG_MSK_MANUAL; // RULE14
        end
    end

    // auto scan enable mask
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            enmask_q <= ACG_RST_ZERO; // RULE15
        end else if (wr_in && hit(addr_in, ACG_OFF_ENMASK)) begin
            enmask_q <= wdata_in; // RULE13
        end
    end

    // input level capture, digital pins only
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            inlvl_q <= ACG_RST_ZERO; // RULE15
        end else begin
            inlvl_q <= pin_level & digital_mask; // RULE8
        end
    end

    // pin drivers
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pin_out_q <= 8'h00;
            pin_oe_q  <= 8'h00;
        end else begin
            for (int i = 0; i < ACG_NCH; i++) begin
                if (!output_mask[i]) begin
                    pin_out_q[i] <= 1'b0;                 // RULE4 RULE11
                    pin_oe_q[i]  <= 1'b0;                 // RULE5
                end else if (drive_q[i]) begin
                    pin_out_q[i] <= outlvl_q[i];          // RULE6 RULE7
                    pin_oe_q[i]  <= 1'b1;                 // RULE6
                end else begin
                    pin_out_q[i] <= 1'b0;                 // RULE6
                    pin_oe_q[i]  <= !outlvl_q[i];         // RULE6 RULE7
                end
            end
        end
    end

    // read mux, unmapped and reserved read as zero
    always_comb begin
        rdata_d = 8'h00;
        unique case (addr_in)
            ACG_OFF_OVERRIDE: rdata_d = override_q;   // RULE14
            ACG_OFF_AVG:      rdata_d = avg_q;        // RULE14
            ACG_OFF_TIMING:   rdata_d = timing_q;     // RULE14
            ACG_OFF_FUNC:     rdata_d = func_q;
            ACG_OFF_DIR:      rdata_d = dir_q;
            ACG_OFF_DRIVE:    rdata_d = drive_q;
            ACG_OFF_OUTLVL:   rdata_d = outlvl_q;
            ACG_OFF_INLVL:    rdata_d = inlvl_q;      // RULE8
            ACG_OFF_SCAN:     rdata_d = scan_q;       // RULE14
            ACG_OFF_MANUAL:   rdata_d = manual_q;     // RULE14
            ACG_OFF_ENMASK:   rdata_d = enmask_q;
            default:          rdata_d = 8'h00;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rdata_q <= 8'h00;
        end else if (rd_in) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= 8'h00;
        end
    end

    // settings to the sequencer
    assign cfg.scan_mode            = acg_scan_mode_t'(scan_q[ACG_LSB_MODE +: 2]); // RULE10
    assign cfg.scan_run             = scan_q[ACG_BIT_RUN];                         // RULE9
    assign cfg.manual_channel_field = manual_q[3:0];
    assign cfg.scan_enable_mask     = enmask_q;
    assign cfg.analog_mask          = ~digital_mask;                               // RULE4 RULE11

    acg_sequencer u_seq (
        .clk_in             (clk_in),
        .resetn_in          (resetn_in),
        .cfg                (cfg.seq_side),
        .conv_done_in       (conv_done_in),
        .channel_out        (channel_out),
        .channel_valid_out  (channel_valid_out)
    );

    // outputs
    assign rdata_out             = rdata_q;
    assign pin_out               = pin_out_q;
    assign pin_oe_out            = pin_oe_q;
    assign averaging_ratio_out   = avg_q[2:0];                    // RULE1
    assign average_samples_out   = samples_q;                     // RULE1
    assign oscillator_choice_out = timing_q[ACG_BIT_OSC];         // RULE2
    assign sample_divider_out    = timing_q[ACG_LSB_DIV +: 4];    // RULE3
    assign analog_mask_out       = ~digital_mask;                 // RULE4
    assign scan_mode_out         = scan_q[ACG_LSB_MODE +: 2];     // RULE10
    assign scan_run_out          = scan_q[ACG_BIT_RUN];           // RULE9
endmodule

// *** testbench/acg_regs_sva.sv ***
// acg_regs_sva: port-level checks of the configuration bank
`timescale 1ns/100ps
module acg_regs_sva
    import acg_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       resetn_in,
    input  wire logic [7:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    input  wire logic [7:0] rdata_out,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe_out,
    input  wire logic       conv_done_in,
    input  wire logic [2:0] averaging_ratio_out,
    input  wire logic [7:0] average_samples_out,
    input  wire logic       oscillator_choice_out,
    input  wire logic [3:0] sample_divider_out,
    input  wire logic [7:0] analog_mask_out,
    input  wire logic [1:0] scan_mode_out,
    input  wire logic       scan_run_out,
    input  wire logic [2:0] channel_out,
    input  wire logic       channel_valid_out
);
    logic       force_q;
    logic [7:0] func_q, dir_q, drv_q, lvl_q, en_q, dig, en_ok, exp_oe, exp_out;
    logic [3:0] man_q;
    // shadow copies of the pin and scan settings
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            {force_q, func_q, dir_q, drv_q, lvl_q, en_q, man_q} <= '0;
        end else if (wr_in) begin
            case (addr_in)
                ACG_OFF_OVERRIDE: force_q <= wdata_in[ACG_BIT_FORCE];
                ACG_OFF_FUNC:     func_q  <= wdata_in;
                ACG_OFF_DIR:      dir_q   <= wdata_in;
                ACG_OFF_DRIVE:    drv_q   <= wdata_in;
                ACG_OFF_OUTLVL:   lvl_q   <= wdata_in;
                ACG_OFF_ENMASK:   en_q    <= wdata_in;
                ACG_OFF_MANUAL:   man_q   <= wdata_in[3:0];
                default: ;
            endcase
        end
    end
    assign dig     = func_q & ~{8{force_q}};
    assign en_ok   = en_q & analog_mask_out;
    assign exp_oe  = dig & dir_q & (drv_q | ~lvl_q);
    assign exp_out = dig & dir_q & drv_q & lvl_q;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    a_timing_reset: assert property ($rose(resetn_in) |-> sample_divider_out == 4'h4
        && !oscillator_choice_out && averaging_ratio_out == 3'h0 && scan_mode_out == 2'h0) else $error("bad reset");
    a_samples_code: assert property (average_samples_out == (8'h01 << $past(averaging_ratio_out)))
        else $error("sample count wrong");
    a_timing_write: assert property (wr_in && addr_in == ACG_OFF_TIMING |=>
        {oscillator_choice_out, sample_divider_out} == $past(wdata_in[4:0])) else $error("timing field wrong");
    a_scan_write: assert property (wr_in && addr_in == ACG_OFF_SCAN |=>
        scan_mode_out == $past(wdata_in[1:0]) && scan_run_out == $past(wdata_in[4])) else $error("scan field wrong");
    a_read_idle: assert property (!$past(rd_in) |-> rdata_out == 8'h00) else $error("read data outside slot");
    a_read_avg: assert property (rd_in && addr_in == ACG_OFF_AVG |=>
        rdata_out == {5'h00, $past(averaging_ratio_out)}) else $error("avg readback wrong");
    a_pin_drive: assert property (pin_oe_out == $past(exp_oe) && pin_out == $past(exp_out))
        else $error("pin drive wrong");
    a_analog_mask: assert property (analog_mask_out == ~dig) else $error("analog mask wrong");
    a_manual_pick: assert property ((scan_mode_out == 2'h0 || scan_mode_out == 2'h2) && !man_q[3]
        && analog_mask_out[man_q[2:0]] |=> channel_valid_out && channel_out == $past(man_q[2:0]))
        else $error("manual channel wrong");
    a_manual_refuse: assert property (scan_mode_out != 2'h1 && (man_q[3] || scan_mode_out == 2'h3
        || !analog_mask_out[man_q[2:0]]) |=> !channel_valid_out) else $error("refused channel valid");
    a_auto_stop: assert property (scan_mode_out == 2'h1 && !scan_run_out |=> !channel_valid_out)
        else $error("stopped scan valid");
    a_auto_member: assert property (channel_valid_out && $past(scan_mode_out) == 2'h1 |->
        (($past(en_ok) >> channel_out) & 8'h01) == 8'h01) else $error("disabled channel scanned");

    c_scan_write: cover property (wr_in && addr_in == ACG_OFF_SCAN);
    c_auto_step: cover property (conv_done_in && channel_valid_out && scan_mode_out == 2'h1);
    c_fly_pick: cover property (channel_valid_out && scan_mode_out == 2'h2);
endmodule
bind acg_regs acg_regs_sva u_sva (.*);

// *** testbench/acg_pin_model.sv ***
// acg_pin_model: board side of the eight pins with pullups and external drivers
`timescale 1ns/100ps
module acg_pin_model (
    input  wire logic [7:0] drv_val_in,
    input  wire logic [7:0] drv_en_in,
    input  wire logic [7:0] ext_en_in,
    input  wire logic [7:0] ext_val_in,
    output logic      [7:0] pin_level_out
);
    // device drive wins, then external driver, else pullup
    assign pin_level_out = (drv_en_in & drv_val_in)
        | (~drv_en_in & ext_en_in & ext_val_in)
        | (~drv_en_in & ~ext_en_in);
endmodule

// *** testbench/tb.sv ***
// tb: register and pin scenarios for the configuration bank
`timescale 1ns/100ps
module tb;
    import acg_pkg::*;
    logic       clk_in = 0, resetn_in = 0, wr_in = 0, rd_in = 0, conv_done_in = 0, osc, run, valid;
    logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, ext_en = 8'h00, ext_val = 8'h00;
    logic [7:0] rdata, pout, poe, plev, samples, amask;
    logic [2:0] ratio, chan;
    logic [3:0] div;
    logic [1:0] mode;
    int         n_fail = 0, cmp_count = 0;
    logic [7:0] ta[12] = '{8'h01, 8'h03, 8'h04, 8'h05, 8'h07, 8'h09, 8'h0b, 8'h0d, 8'h10, 8'h11, 8'h12, 8'h20};
    logic [7:0] rv[12] = '{8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] mk[12] = '{8'h04, 8'h07, 8'h1f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h13, 8'h0f, 8'hff, 8'h00};

    always #12.5 clk_in = ~clk_in;

    acg_regs DUT (.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata),
        .clk_in(clk_in), .resetn_in(resetn_in), .pin_in(plev), .pin_out(pout), .pin_oe_out(poe),
        .conv_done_in(conv_done_in), .averaging_ratio_out(ratio), .average_samples_out(samples),
        .oscillator_choice_out(osc), .sample_divider_out(div), .analog_mask_out(amask),
        .scan_mode_out(mode), .scan_run_out(run), .channel_out(chan), .channel_valid_out(valid));
    acg_pin_model PM (.drv_val_in(pout), .drv_en_in(poe), .ext_en_in(ext_en), .ext_val_in(ext_val),
        .pin_level_out(plev));

    task report_and_stop;
        if (n_fail == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        wr_in <= 1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_in);
        rd_in <= 1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in <= 0;
        #1 chk(rdata, e);
    endtask
    task sq(input logic v, input logic [2:0] c);
        tick(2);
        chk({4'h0, valid, v ? chan : 3'h0}, {4'h0, v, c});
    endtask
    task pulse;
        @(posedge clk_in);
        conv_done_in <= 1;
        @(posedge clk_in);
        conv_done_in <= 0;
    endtask

    initial begin
        repeat (5) @(posedge clk_in);
        resetn_in <= 1;
        for (int i = 0; i < 12; i++) rd(ta[i], rv[i]);
        for (int i = 0; i < 12; i++) wr(ta[i], 8'hff);
        for (int i = 0; i < 12; i++) rd(ta[i], mk[i]);
        @(posedge clk_in);
        resetn_in <= 0;
        repeat (2) @(posedge clk_in);
        resetn_in <= 1;
        for (int i = 0; i < 12; i++) rd(ta[i], rv[i]);
        for (int i = 0; i < 8; i++) begin
            wr(ACG_OFF_AVG, 8'hf8 | 8'(i));
            tick(2);
            chk(samples, 8'h01 << i);
            chk({5'h00, ratio}, 8'(i));
        end
        wr(ACG_OFF_TIMING, 8'hfa);
        tick(2);
        chk({3'h0, osc, div}, 8'h1a);
        ext_en <= 8'hf0;
        ext_val <= 8'ha0;
        wr(ACG_OFF_FUNC, 8'hff);
        wr(ACG_OFF_DIR, 8'h0f);
        wr(ACG_OFF_DRIVE, 8'h05);
        wr(ACG_OFF_OUTLVL, 8'h03);
        tick(6);
        chk(poe, 8'h0d);
        chk(pout, 8'h01);
        rd(ACG_OFF_INLVL, 8'ha3);
        wr(ACG_OFF_FUNC, 8'h0f);
        tick(6);
        chk(amask, 8'hf0);
        rd(ACG_OFF_INLVL, 8'h03);
        wr(ACG_OFF_OVERRIDE, 8'h04);
        tick(6);
        chk(amask, 8'hff);
        chk(poe, 8'h00);
        rd(ACG_OFF_INLVL, 8'h00);
        wr(ACG_OFF_OVERRIDE, 8'h00);
        wr(ACG_OFF_MANUAL, 8'h05);
        sq(1, 3'h5);
        wr(ACG_OFF_MANUAL, 8'h02);
        sq(0, 3'h0);
        wr(ACG_OFF_MANUAL, 8'h0e);
        sq(0, 3'h0);
        wr(ACG_OFF_SCAN, 8'h02);
        wr(ACG_OFF_MANUAL, 8'h06);
        sq(1, 3'h6);
        wr(ACG_OFF_SCAN, 8'h03);
        sq(0, 3'h0);
        wr(ACG_OFF_ENMASK, 8'h3a);
        wr(ACG_OFF_SCAN, 8'h11);
        sq(1, 3'h4);
        chk({3'h0, run, 2'h0, mode}, 8'h11);
        pulse;
        sq(1, 3'h5);
        pulse;
        sq(1, 3'h4);
        wr(ACG_OFF_SCAN, 8'h01);
        sq(0, 3'h0);
        report_and_stop;
    end

    initial begin
        repeat (20000) @(posedge clk_in);
        n_fail++;
        report_and_stop;
    end
endmodule
